// ==== logic/ycs_pkg.sv ====
`default_nettype none
package ycs_pkg;
   // clock and line geometry
   localparam real SYS_CLK_MHZ     = 20.25;
   localparam int  HCLK_MHZ        = 250;
   localparam int  LINE_LEN        = 1296;
   localparam int  LINE_AW         = 11;
   localparam int  SAMPLE_W        = 8;
   // register byte offsets
   localparam logic [7:0] CTRL_OFF   = 8'h00;
   localparam logic [7:0] GAIN_OFF   = 8'h04;
   localparam logic [7:0] STATUS_OFF = 8'h08;
   localparam logic [7:0] LINE_OFF   = 8'h0c;
   // control fields
   localparam int CTRL_EN_BIT     = 0;
   localparam int CTRL_BOOST_BIT  = 1;
   localparam int CTRL_FOLLOW_BIT = 2;
   localparam int CTRL_RAIN_BIT   = 3;
   localparam int CTRL_LIM_LSB    = 8;
   localparam int LIM_W           = 5;
   localparam int GAIN_W          = 5;
   localparam int GAIN_LUMA_LSB   = 0;
   localparam int GAIN_CHROMA_LSB = 8;
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   localparam logic [31:0] GAIN_RST = 32'h0000_1010;
   localparam logic [GAIN_W-1:0] GAIN_FULL = 5'h10;
   localparam logic [LINE_AW-1:0] LINE_LEN_RST = 11'h510;
   localparam logic [LINE_AW-1:0] LINE_LAST_MIN = 11'h00f;
   // weighting
   localparam int WEIGHT_W  = 5;
   localparam logic [WEIGHT_W-1:0] WEIGHT_MAX = 5'h10;
   localparam int RAIN_THR  = 4;
   localparam int BOOST_SH0 = 2;
   localparam int BOOST_SH1 = 1;
endpackage : ycs_pkg
`default_nettype wire

// ==== logic/ycs_line_mem.sv ====
`default_nettype none
module ycs_line_mem
   import ycs_pkg::*;
(
   input  wire logic                hclk,
   input  wire logic                we,
   input  wire logic [LINE_AW-1:0]  addr,
   input  wire logic [15:0]         wdata,
   output logic      [15:0]         rdata
);
   logic [15:0] mem [0:(1<<LINE_AW)-1];

   // read-before-write: old line comes out while new is stored
   always_ff @(posedge hclk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule : ycs_line_mem
`default_nettype wire

// ==== logic/ycs_skid.sv ====
`default_nettype none
module ycs_skid
   import ycs_pkg::*;
#(
   parameter int W = 16
)
(
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic          in_valid,
   output logic               in_ready,
   input  wire logic [W-1:0]  in_data,
   output logic               out_valid,
   input  wire logic          out_ready,
   output logic      [W-1:0]  out_data
);
   logic [W-1:0] buf_r [0:1];
   logic         wp_r;
   logic         rp_r;
   logic [1:0]   cnt_r;
   logic         push;
   logic         pop;

   assign in_ready  = (cnt_r != 2'd2);
   assign out_valid = (cnt_r != 2'd0);
   assign out_data  = buf_r[rp_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge hclk) begin
      if (push) begin
         buf_r[wp_r] <= in_data;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp_r  <= 1'b0;
         rp_r  <= 1'b0;
         cnt_r <= 2'd0;
      end else begin
         if (push) wp_r <= ~wp_r;
         if (pop) rp_r <= ~rp_r;
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule : ycs_skid
`default_nettype wire

// ==== logic/ycs_comb_filter.sv ====
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`default_nettype none
// Operation
// - separate luma and chroma adaptively for composite PAL/NTSC only
// - two line delays give three adjacent lines at once
// - all processing on one system clock locked to subcarrier
// - bandpass/notch per line; adaption picks weights for four signals
// - soft weighted mixing, never hard switching between filter signals
// - centre line is reference; outputs delayed exactly one line
// - comb off still routes samples through delays; latency stays one line
// - separate luma and chroma gains scale the adaption output
// - gain zero gives notch/bandpass, full gain gives full comb
// - booster bit: 0 moderate, 1 maximum vertical transition enhancement
// - five-bit limit caps luma comb, 0 none to 31 maximum
// - rain suppressor disabled when bit is 1, enabled when 0
module ycs_comb_filter
   import ycs_pkg::*;
(
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic      [31:0]          hrdata,
   output logic                      hreadyout,
   output logic                      hresp,
   input  wire logic                 in_valid,
   output logic                      in_ready,
   input  wire logic [SAMPLE_W-1:0]  cvbs_in,
   input  wire logic [SAMPLE_W-1:0]  chroma_in,
   input  wire logic                 composite_mode,
   input  wire logic                 line_start,
   output logic                      out_valid,
   input  wire logic                 out_ready,
   output logic      [SAMPLE_W-1:0]  luma_out,
   output logic      [SAMPLE_W-1:0]  chroma_out
);
   // bus slave
   logic [31:0]        ctrl_r;
   logic [31:0]        gain_r;
   logic [LINE_AW-1:0] line_len_r;
   logic               wr_pend_r;
   logic [7:0]         wr_addr_r;
   logic               ctrl_en_r;
   logic               boost_r;
   logic               follow_r;
   logic               rain_dis_r;
   logic [LIM_W-1:0]   limit_r;
   logic [GAIN_W-1:0]  luma_comb_gain_r;
   logic [GAIN_W-1:0]  chroma_comb_gain_r;
   logic [LINE_AW-1:0] act_len_r;
   logic [15:0]        line_cnt_r;
   logic [7:0]         rd_off;
   logic               rd_go;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   // upper address bits must be zero, otherwise unmapped
   assign rd_off    = (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hff;
   assign rd_go     = hsel && hready && htrans[1] && !hwrite;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else if (hready) begin
         wr_pend_r <= hsel && htrans[1] && hwrite;
         wr_addr_r <= rd_off;
      end
   end

   // software-visible settings, reset to defaults
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r     <= CTRL_RST;
         gain_r     <= GAIN_RST;
         line_len_r <= LINE_LEN_RST;
      end else if (wr_pend_r) begin
         unique case (wr_addr_r)
            CTRL_OFF: ctrl_r <= hwdata;
            GAIN_OFF: gain_r <= hwdata;
            LINE_OFF: line_len_r <= (hwdata[LINE_AW-1:0] < LINE_LAST_MIN) ? LINE_LAST_MIN
                                    : hwdata[LINE_AW-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_go) begin
         unique case (rd_off)
            CTRL_OFF:   hrdata <= ctrl_r;
            GAIN_OFF:   hrdata <= gain_r;
            STATUS_OFF: hrdata <= {line_cnt_r, 15'h0000, ctrl_en_r};
            LINE_OFF:   hrdata <= {21'h00_0000, line_len_r};
            default:    hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // line timing
   logic [LINE_AW-1:0] pos_r;
   logic [LINE_AW-1:0] wr_pos;
   logic               adv;
   logic               at_line;
   logic               sk_ready;
   logic               v1_r;

   // take only if the sample still finds room when it reaches the buffer
   assign in_ready = !out_valid || (out_ready && (sk_ready || !v1_r)) || (sk_ready && !v1_r);
   assign adv      = in_valid && in_ready;
   assign wr_pos   = line_start ? '0 : pos_r;
   assign at_line  = adv && (wr_pos == '0);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pos_r      <= '0;
         line_cnt_r <= 16'h0000;
      end else if (adv) begin
         pos_r <= (wr_pos == act_len_r) ? '0 : wr_pos + 1'b1;
         if (at_line) line_cnt_r <= line_cnt_r + 16'h0001;
      end
   end

   // settings latched only at a line boundary
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_en_r          <= CTRL_RST[CTRL_EN_BIT];
         boost_r            <= CTRL_RST[CTRL_BOOST_BIT];
         follow_r           <= CTRL_RST[CTRL_FOLLOW_BIT];
         rain_dis_r         <= CTRL_RST[CTRL_RAIN_BIT];
         limit_r            <= CTRL_RST[CTRL_LIM_LSB +: LIM_W];
         luma_comb_gain_r   <= GAIN_RST[GAIN_LUMA_LSB +: GAIN_W];
         chroma_comb_gain_r <= GAIN_RST[GAIN_CHROMA_LSB +: GAIN_W];
         act_len_r          <= LINE_LEN_RST;
      end else if (at_line) begin
         ctrl_en_r          <= ctrl_r[CTRL_EN_BIT];
         boost_r            <= ctrl_r[CTRL_BOOST_BIT];
         follow_r           <= ctrl_r[CTRL_FOLLOW_BIT];
         rain_dis_r         <= ctrl_r[CTRL_RAIN_BIT];
         limit_r            <= ctrl_r[CTRL_LIM_LSB +: LIM_W];
         luma_comb_gain_r   <= gain_r[GAIN_LUMA_LSB +: GAIN_W];
         chroma_comb_gain_r <= gain_r[GAIN_CHROMA_LSB +: GAIN_W];
         act_len_r          <= line_len_r;
      end
   end

   // two line delays
   logic [15:0] d1_q;
   logic [15:0] d2_q;
   logic [15:0] cur_w;
   logic [15:0] cur_r;
   logic [15:0] d1_hold_r;
   logic [15:0] d2_wr;

   assign cur_w = {cvbs_in, chroma_in};
   // last line-old sample, whatever the spacing; bottom line trails by one sample
   assign d2_wr = v1_r ? d1_q : d1_hold_r;

   ycs_line_mem u_delay1 (
      .hclk  (hclk),
      .we    (adv),
      .addr  (wr_pos),
      .wdata (cur_w),
      .rdata (d1_q)
   );

   ycs_line_mem u_delay2 (
      .hclk  (hclk),
      .we    (adv),
      .addr  (wr_pos),
      .wdata (d2_wr),
      .rdata (d2_q)
   );

   // d1 read is valid only in the cycle after a take
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur_r     <= 16'h0000;
         v1_r      <= 1'b0;
         d1_hold_r <= 16'h0000;
      end else begin
         v1_r <= adv;
         if (adv) cur_r <= cur_w;
         if (v1_r) d1_hold_r <= d1_q;
      end
   end

   // filters and adaption
   // lines: top = newest (cur_r), mid = d1_q reference, bot = d2_q
   logic signed [9:0] top_s, mid_s, bot_s;
   logic signed [9:0] bp_top, bp_mid, bp_bot;
   logic signed [9:0] dif_t, dif_b;
   logic [9:0]        ad_t, ad_b;
   logic [WEIGHT_W-1:0] w_luma, w_chr, w_lim, w_boost;
   logic [SAMPLE_W-1:0] mid_prev_r, mid_prev2_r;

   assign top_s = {2'b00, cur_r[15:8]};
   assign mid_s = {2'b00, d1_q[15:8]};
   assign bot_s = {2'b00, d2_q[15:8]};

   // subcarrier at quarter rate: bandpass from samples two apart
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mid_prev_r  <= 8'h00;
         mid_prev2_r <= 8'h00;
      end else if (v1_r) begin
         mid_prev_r  <= d1_q[15:8];
         mid_prev2_r <= mid_prev_r;
      end
   end

   assign bp_mid = (mid_s - $signed({2'b00, mid_prev2_r})) >>> 1;
   assign bp_top = (top_s - mid_s) >>> 1;
   assign bp_bot = (bot_s - mid_s) >>> 1;
   assign dif_t  = bp_top + bp_mid;
   assign dif_b  = bp_bot + bp_mid;
   assign ad_t   = dif_t[9] ? 10'(-dif_t) : dif_t;
   assign ad_b   = dif_b[9] ? 10'(-dif_b) : dif_b;

   // weight from vertical similarity; small differences mean full comb
   function automatic logic [WEIGHT_W-1:0] simil(input logic [9:0] d);
      logic [9:0] t;
      t = (d > 10'(WEIGHT_MAX)) ? 10'(WEIGHT_MAX) : d;
      simil = WEIGHT_MAX - t[WEIGHT_W-1:0];
   endfunction

   logic [WEIGHT_W-1:0] w_raw;
   logic [9:0]          ad_min;
   assign ad_min  = (ad_t < ad_b) ? ad_t : ad_b;
   assign w_raw   = simil(ad_min);
   assign w_boost = boost_r ? WEIGHT_W'(w_raw + (w_raw >> BOOST_SH1))
                            : WEIGHT_W'(w_raw + (w_raw >> BOOST_SH0));
   assign w_lim   = (w_boost > WEIGHT_MAX) ? WEIGHT_MAX : w_boost;

   // rain suppression: uncorrelated noise in flat area halves luma comb weight; chroma weight only when it follows luma
   logic                rain_hit;
   logic [WEIGHT_W-1:0] w_rain;
   assign rain_hit = !rain_dis_r && (ad_t < 10'(RAIN_THR)) && (ad_b < 10'(RAIN_THR));
   assign w_rain   = rain_hit ? (w_lim >> 1) : w_lim;

   // luma limit and gains; gain 0 notch only, GAIN_FULL full comb
   logic [10:0] ly_prod, lc_prod;
   logic [WEIGHT_W-1:0] w_luma_g, w_chr_raw;
   assign ly_prod  = 11'(w_rain) * 11'(luma_comb_gain_r);
   assign w_luma_g = (ly_prod[10:4] > 7'(WEIGHT_MAX)) ? WEIGHT_MAX : ly_prod[8:4];
   assign w_luma   = (w_luma_g > WEIGHT_W'(WEIGHT_MAX - (limit_r >> 1)))
                     ? WEIGHT_W'(WEIGHT_MAX - (limit_r >> 1)) : w_luma_g;
   assign w_chr_raw = follow_r ? w_luma : w_lim;
   assign lc_prod  = 11'(w_chr_raw) * 11'(chroma_comb_gain_r);
   assign w_chr    = (lc_prod[10:4] > 7'(WEIGHT_MAX)) ? WEIGHT_MAX : lc_prod[8:4];

   // soft mix of notch (mid-bp_mid) with comb (mid-vertical avg)
   logic signed [9:0]  comb_c, notch_c;
   logic signed [15:0] chr_mix;
   logic signed [15:0] y_mix;
   assign notch_c = bp_mid;
   assign comb_c  = (bp_top + bp_bot) >>> 1;
   // weights made signed so the products and the shift keep the sign
   assign chr_mix = (16'(notch_c) * $signed(16'(WEIGHT_MAX - w_chr))
                    + 16'(-comb_c) * $signed(16'(w_chr))) >>> 4;
   assign y_mix   = 16'(mid_s) - ((16'(notch_c) * $signed(16'(WEIGHT_MAX - w_luma))
                    + 16'(-comb_c) * $signed(16'(w_luma))) >>> 4);

   function automatic logic [7:0] sat8(input logic signed [15:0] v);
      sat8 = (v < 0) ? 8'h00 : (v > 16'sd255) ? 8'hff : v[7:0];
   endfunction

   logic [7:0] y_sel, c_sel;
   logic signed [15:0] c_bias;
   assign c_bias = chr_mix + 16'sd128;
   // comb only for composite input; otherwise just the delayed samples
   always_comb begin
      if (ctrl_en_r && composite_mode) begin
         y_sel = sat8(y_mix);
         c_sel = sat8(c_bias);
      end else begin
         y_sel = d1_q[15:8];
         c_sel = d1_q[7:0];
      end
   end

   // output buffer
   logic [15:0] sk_data;
   ycs_skid #(.W(16)) u_out (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .in_valid  (v1_r),
      .in_ready  (sk_ready),
      .in_data   ({y_sel, c_sel}),
      .out_valid (out_valid),
      .out_ready (out_ready),
      .out_data  (sk_data)
   );
   assign luma_out   = sk_data[15:8];
   assign chroma_out = sk_data[7:0];
endmodule : ycs_comb_filter
`default_nettype wire

// ==== verification/ycs_comb_filter_sva.sv ====
`default_nettype none
module ycs_comb_filter_sva
   import ycs_pkg::*;
(
   input wire logic                hclk,
   input wire logic                hresetn,
   input wire logic                hsel,
   input wire logic [31:0]         haddr,
   input wire logic [1:0]          htrans,
   input wire logic                hwrite,
   input wire logic                hready,
   input wire logic [31:0]         hrdata,
   input wire logic                hreadyout,
   input wire logic                hresp,
   input wire logic                in_valid,
   input wire logic                in_ready,
   input wire logic                out_valid,
   input wire logic                out_ready,
   input wire logic [SAMPLE_W-1:0] luma_out,
   input wire logic [SAMPLE_W-1:0] chroma_out
);
   timeunit 1ns;
   timeprecision 100ps;
   wire logic  take = in_valid && in_ready;
   wire logic  rd_a = hsel && hready && htrans[1] && !hwrite;
   logic [3:0] pend_r;
   // samples taken but not yet handed on
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) pend_r <= 4'h0;
      else pend_r <= pend_r + {3'h0, take} - {3'h0, out_valid && out_ready};
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus wait or error");
   rdata_hold_a: assert property ($changed(hrdata) |-> $past(rd_a))
      else $error("read data moved without read");
   unmapped_zero_a: assert property (rd_a && haddr[31:4] != 28'h000_0000 |=> hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   out_lat_a: assert property (take |-> ##2 out_valid)
      else $error("output late");
   out_cause_a: assert property ($rose(out_valid) |-> $past(take, 2))
      else $error("output without input");
   pair_a: assert property (out_valid |-> pend_r != 4'h0)
      else $error("more outputs than inputs");
   hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable({luma_out, chroma_out}))
      else $error("output lost in stall");
   refuse_a: assert property (!in_ready |-> out_valid)
      else $error("refused with empty buffer");
endmodule // ycs_comb_filter_sva
bind ycs_comb_filter ycs_comb_filter_sva ycs_comb_filter_sva_inst (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .in_valid(in_valid),
   .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready), .luma_out(luma_out),
   .chroma_out(chroma_out));
`default_nettype wire

// ==== verification/ycs_video_peer.sv ====
`default_nettype none
module ycs_video_peer
   import ycs_pkg::*;
#(
   parameter int LINE_N = 16
)
(
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic [15:0]         rnd,
   input  wire logic                run,
   input  wire logic                slow,
   input  wire logic                stall,
   input  wire logic                in_ready,
   output logic                     in_valid,
   output logic      [SAMPLE_W-1:0] cvbs_in,
   output logic      [SAMPLE_W-1:0] chroma_in,
   output logic                     line_start,
   output logic                     out_ready
);
   timeunit 1ns;
   timeprecision 100ps;
   wire logic take = in_valid && in_ready;
   int        pos_r;
   logic      half_r;
   // sample held until taken; idle data keeps moving
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_valid   <= 1'b0;
         cvbs_in    <= 8'h00;
         chroma_in  <= 8'h80;
         line_start <= 1'b0;
         out_ready  <= 1'b0;
         pos_r      <= 0;
         half_r     <= 1'b0;
      end else begin
         out_ready <= !stall && (!slow || rnd[0]);
         if (take) pos_r <= (pos_r + 1) % LINE_N;
         if (!in_valid || in_ready) begin
            in_valid   <= run && (!slow || rnd[1]);
            cvbs_in    <= rnd[7:0];
            half_r     <= !half_r;
            chroma_in  <= half_r ? chroma_in : rnd[15:8];
            line_start <= ((take ? pos_r + 1 : pos_r) % LINE_N) == 0;
         end
      end
   end
endmodule // ycs_video_peer
`default_nettype wire

// ==== verification/ycs_comb_filter_tb.sv ====
`default_nettype none
module ycs_comb_filter_tb import ycs_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int LINE_N = int'(LINE_LAST_MIN) + 1;
   localparam logic [7:0] W_A [9] = '{CTRL_OFF, CTRL_OFF, CTRL_OFF, CTRL_OFF, GAIN_OFF, GAIN_OFF, GAIN_OFF,
      LINE_OFF, CTRL_OFF};
   localparam logic [31:0] W_D [9] = '{32'h0000_0003, 32'h0000_0005, 32'h0000_0009, 32'h0000_1f01,
      32'h0000_0000, 32'h0000_1f1f, 32'h0000_1010, 32'h0000_000f, 32'h0000_0000};
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, in_valid, in_ready, line_start;
   logic        composite_mode, out_valid, out_ready, run, slow, stall, byp, nch;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  cvbs_in, chroma_in, luma_out, chroma_out;
   logic [15:0] rnd;
   logic [15:0] hist [0:4095];
   int          error_cnt, tests_run, in_cnt, out_cnt, skip;
   ycs_comb_filter ycs_comb_filter_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .in_valid(in_valid), .in_ready(in_ready), .cvbs_in(cvbs_in),
      .chroma_in(chroma_in), .composite_mode(composite_mode), .line_start(line_start),
      .out_valid(out_valid), .out_ready(out_ready), .luma_out(luma_out), .chroma_out(chroma_out));
   ycs_video_peer #(.LINE_N(LINE_N)) ycs_video_peer_inst (.hclk(hclk), .hresetn(hresetn), .rnd(rnd),
      .run(run), .slow(slow), .stall(stall), .in_ready(in_ready), .in_valid(in_valid), .cvbs_in(cvbs_in),
      .chroma_in(chroma_in), .line_start(line_start), .out_ready(out_ready));
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [31:0] expect_of(input int k);
      return {16'h0000, hist[k - LINE_N]};
   endfunction
   function automatic logic [7:0] sat(input int v);
      return (v < 0) ? 8'h00 : (v > 255) ? 8'hff : 8'(v);
   endfunction
   // zero gains: luma is centre minus bandpass, chroma the bandpass around 128
   function automatic logic [31:0] expect_notch(input int k);
      int m;
      int n;
      m = int'(hist[k - LINE_N][15:8]);
      n = (m - int'(hist[k - LINE_N - 2][15:8])) >>> 1;
      return {16'h0000, sat(m - n), sat(n + 128)};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000, rd);
      check(rd, exp);
   endtask
   task automatic give_verdict;
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   always @(posedge hclk) rnd <= lfsr(rnd);
   // record taken samples, compare bypass output one line later
   always @(posedge hclk) begin
      if (in_valid && in_ready) begin
         hist[in_cnt] = {cvbs_in, chroma_in};
         in_cnt++;
      end
      if (out_valid && out_ready) begin
         if (byp && out_cnt >= skip) check({16'h0000, luma_out, chroma_out}, expect_of(out_cnt));
         if (nch && out_cnt >= skip) check({16'h0000, luma_out, chroma_out}, expect_notch(out_cnt));
         out_cnt++;
      end
   end
   initial begin
      repeat (30000) @(posedge hclk);
      error_cnt++;
      give_verdict;
   end
   initial begin
      {hsel, hwrite, run, slow, stall, byp, nch} = 7'h00;
      {hresetn, composite_mode, htrans, hsize} = 7'h22;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      rnd = 16'h0008;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      reg_rd(CTRL_OFF, CTRL_RST);
      reg_rd(GAIN_OFF, GAIN_RST);
      reg_rd(LINE_OFF, {21'h00_0000, LINE_LEN_RST});
      reg_rd(8'h10, 32'h0000_0000);
      for (int i = 0; i < 9; i++) begin
         bus(1'b1, W_A[i], W_D[i], rd);
         reg_rd(W_A[i], W_D[i]);
      end
      bus(1'b1, 8'h10, 32'hffff_ffff, rd);
      reg_rd(CTRL_OFF, 32'h0000_0000);
      bus(1'b0, STATUS_OFF, 32'h0000_0000, rd);
      check({31'h0000_0000, rd[0]}, 32'h0000_0001);
      // comb off by register: two lines to fill, then compare
      byp <= 1'b1;
      skip <= 2 * LINE_N;
      slow <= 1'b1;
      run <= 1'b1;
      while (in_cnt < 8 * LINE_N) @(posedge hclk);
      bus(1'b0, STATUS_OFF, 32'h0000_0000, rd);
      check({31'h0000_0000, rd[0]}, 32'h0000_0000);
      // non-composite source with comb enabled, then fill the buffer
      composite_mode <= 1'b0;
      bus(1'b1, CTRL_OFF, 32'h0000_0001, rd);
      skip <= in_cnt + 3 * LINE_N;
      slow <= 1'b0;
      while (in_cnt < 12 * LINE_N) @(posedge hclk);
      stall <= 1'b1;
      while (in_ready !== 1'b0) @(negedge hclk);
      check({31'h0000_0000, out_valid}, 32'h0000_0001);
      @(posedge hclk);
      stall <= 1'b0;
      while (in_cnt < 16 * LINE_N) @(posedge hclk);
      // comb on with zero gains: plain notch/bandpass values checked
      byp <= 1'b0;
      composite_mode <= 1'b1;
      bus(1'b1, CTRL_OFF, {19'h0_0000, rnd[12:8], 4'h0, rnd[3:1], 1'b1}, rd);
      bus(1'b1, GAIN_OFF, 32'h0000_0000, rd);
      skip <= in_cnt + 3 * LINE_N;
      nch <= 1'b1;
      while (in_cnt < 22 * LINE_N) @(posedge hclk);
      // random gains: one output per input
      nch <= 1'b0;
      bus(1'b1, GAIN_OFF, {19'h0_0000, rnd[12:8], 3'h0, rnd[4:0]}, rd);
      slow <= 1'b1;
      while (in_cnt < 26 * LINE_N) @(posedge hclk);
      run <= 1'b0;
      for (int i = 0; i < 400 && out_cnt != in_cnt; i++) @(posedge hclk);
      check(out_cnt, in_cnt);
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      reg_rd(CTRL_OFF, CTRL_RST);
      give_verdict;
   end
endmodule // ycs_comb_filter_tb
`default_nettype wire
